// [rtl/nbac_pkg.sv]
// Constants for the per-block access control of the 4-Kbit memory.
// Assumes byte addressing of a 512-byte array, 16 bytes to a block.
package nbac_pkg;
  localparam int          NUM_BLOCKS   = 32;
  localparam int          BLOCK_BYTES  = 16;
  localparam int          ADDR_W       = 9;
  localparam int          BLK_W        = 5;
  localparam int          USER_LAST    = 26;
  localparam int          SYS_FIRST    = 27;
  localparam int          MAP_W        = 27;
  localparam int          MAP_BYTES    = 4;
  localparam int          NUM_MAPS     = 3;
  localparam logic [8:0]  RF_MAP_OFS   = 9'h1f0;
  localparam logic [8:0]  SER_MAP_OFS  = 9'h1f4;
  localparam logic [8:0]  QUAL_MAP_OFS = 9'h1f8;
  localparam logic [26:0] MAP_RESET    = 27'h0;
  localparam logic [4:0]  SYS_BLK_LO   = 5'h1b;
endpackage

// [rtl/nbac_perm_if.sv]
// Carrier between the access controller and its permission evaluator.
// Assumes both ends sit on the same clock; the path is combinational.
`timescale 1ns/1ps
`default_nettype none
interface nbac_perm_if;
  import nbac_pkg::*;
  logic [MAP_W-1:0] rf_map;
  logic [MAP_W-1:0] ser_map;
  logic [MAP_W-1:0] qual_map;
  logic [BLK_W-1:0] blk;
  logic             rf;
  logic             enc;
  logic             can_read;
  logic             can_write;
  modport ctrl (output rf_map, ser_map, qual_map, blk, rf, enc,
                input  can_read, can_write);
  modport eval (input  rf_map, ser_map, qual_map, blk, rf, enc,
                output can_read, can_write);
endinterface
`default_nettype wire

// [rtl/nbac_perm_eval.sv]
// Permission evaluator: decides read and write rights for one block.
// Assumes the maps are held stable by the controller; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module nbac_perm_eval (
  nbac_perm_if.eval pif
);
  import nbac_pkg::*;

  logic [NUM_BLOCKS-1:0] wr_ok;
  logic [NUM_BLOCKS-1:0] rd_ok;

  // ----------------------------------------------------------------
  // Per-block rights
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NUM_BLOCKS; b++) begin : g_blk
      if (b <= USER_LAST) begin : g_user
        wire ro   = pif.rf_map[b];
        wire q    = pif.qual_map[b];
        wire sro  = pif.ser_map[b];
        // Encrypted RF traffic may still write when the qualifier is set.
        wire rf_w = pif.enc ? (!ro || q) : (!ro && !q);
        wire rf_r = pif.enc ? 1'b1 : (ro || !q);
        assign wr_ok[b] = pif.rf ? rf_w : !sro;
        assign rd_ok[b] = pif.rf ? rf_r : 1'b1;
      end else begin : g_sys
        // System blocks carry the settings and are not mapped.
        assign wr_ok[b] = 1'b1;
        assign rd_ok[b] = 1'b1;
      end
    end
  endgenerate

  assign pif.can_write = wr_ok[pif.blk];
  assign pif.can_read  = rd_ok[pif.blk];
endmodule
`default_nettype wire

// [rtl/nbac_access_ctrl.sv]
// Access controller in front of the 4-Kbit non-volatile memory.
// Assumes commands arrive from logic on mclk; memory write timing is
// handled by the array beyond mem_we.
//
// Functional notes
// - The memory is 32 blocks of 16 bytes, addressed by byte.
// - Blocks 0 to 26 are user area, blocks 27 to 31 system area.
// - Block n starts at byte n times 0x10.
// - Communication and access settings live in the system area.
// - Each user block has one RF permission bit used only in RF mode.
// - RF bit and qualifier bit combine into plaintext/encrypted rights.
// - The RF bit of block b sits at 0x1f0 plus b/8, bit b mod 8.
// - All permission bits are 0 after reset, so all blocks are writable.
// - Each user block has a serial bit: 0 read/write, 1 read only.
// - The serial bit of block b sits at 0x1f4 plus b/8, bit b mod 8.
// - The qualifier bit of block b sits at 0x1f8 plus b/8, bit b mod 8.
// - Qualifier bits count only in RF mode.
`timescale 1ns/1ps
`default_nettype none
module nbac_access_ctrl (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   cmd_valid,
  input  wire logic                   cmd_write,
  input  wire logic                   cmd_rf,
  input  wire logic                   cmd_encrypted,
  input  wire logic [nbac_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]             cmd_wdata,
  output logic                        rsp_valid,
  output logic                        rsp_ok,
  output logic                        mem_we,
  output logic [nbac_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0]                  mem_wdata
);
  import nbac_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  nbac_perm_if pif ();

  logic [NUM_MAPS-1:0][MAP_W-1:0] map_ff;
  logic [NUM_MAPS-1:0][MAP_W-1:0] nxt_map;
  logic                           rsp_valid_ff;
  logic                           rsp_ok_ff;
  logic                           mem_we_ff;
  logic [ADDR_W-1:0]              mem_addr_ff;
  logic [7:0]                     mem_wdata_ff;

  wire [BLK_W-1:0] cmd_blk = cmd_addr[ADDR_W-1:4];
  wire             grant   = cmd_write ? pif.can_write : pif.can_read;
  wire             wr_go   = ce && cmd_valid && cmd_write && pif.can_write;

  assign pif.rf_map   = map_ff[0];
  assign pif.ser_map  = map_ff[1];
  assign pif.qual_map = map_ff[2];
  assign pif.blk      = cmd_blk;
  assign pif.rf       = cmd_rf;
  assign pif.enc      = cmd_encrypted;

  nbac_perm_eval u_eval (
    .pif (pif)
  );

  // ----------------------------------------------------------------
  // Shadow of the permission bytes
  // ----------------------------------------------------------------
  // The maps mirror their system bytes; bits above block 26 fall away, so
  // reserved positions stay 0 in map_ff, while mem_wdata still carries them to the array.
  genvar m, k;
  generate
    for (m = 0; m < NUM_MAPS; m++) begin : g_map
      logic [8*MAP_BYTES-1:0] cur;
      logic [8*MAP_BYTES-1:0] nxt;
      assign cur = {{(8*MAP_BYTES-MAP_W){1'b0}}, map_ff[m]};
      for (k = 0; k < MAP_BYTES; k++) begin : g_byte
        wire hit = wr_go &&
          (cmd_addr == RF_MAP_OFS + 9'(m * MAP_BYTES + k));
        assign nxt[8*k+:8] = hit ? cmd_wdata : cur[8*k+:8];
      end
      assign nxt_map[m] = nxt[MAP_W-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      map_ff <= {NUM_MAPS{MAP_RESET}};
    end else if (ce) begin
      map_ff <= nxt_map;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_ok_ff    <= 1'b0;
      mem_we_ff    <= 1'b0;
    end else if (ce) begin
      rsp_valid_ff <= cmd_valid;
      rsp_ok_ff    <= cmd_valid && grant;
      mem_we_ff    <= wr_go;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_addr_ff  <= '0;
      mem_wdata_ff <= 8'h00;
    end else if (ce && cmd_valid) begin
      mem_addr_ff  <= cmd_addr;
      mem_wdata_ff <= cmd_wdata;
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_ok    = rsp_ok_ff;
  assign mem_we    = mem_we_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire go   = ce && cmd_valid;
  wire user = cmd_blk <= BLK_W'(USER_LAST);

  property p_refuse_ro;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && !pif.can_write |=> !mem_we && !rsp_ok;
  endproperty
  a_refuse_ro: assert property (p_refuse_ro)
    else $error("write to protected block reached memory");

  property p_plain_forbid;
    @(posedge mclk) disable iff (rst)
      go && cmd_rf && !cmd_encrypted && user && map_ff[2][cmd_blk]
        && !map_ff[0][cmd_blk] |=> rsp_valid && !rsp_ok;
  endproperty
  a_plain_forbid: assert property (p_plain_forbid)
    else $error("plaintext access to qualified block granted");

  property p_enc_write;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && cmd_rf && cmd_encrypted && user
        && map_ff[2][cmd_blk] |=> mem_we && rsp_ok;
  endproperty
  a_enc_write: assert property (p_enc_write)
    else $error("encrypted write to qualified block refused");

  property p_rf_ro;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && cmd_rf && user && map_ff[0][cmd_blk]
        && !map_ff[2][cmd_blk] |=> !mem_we;
  endproperty
  a_rf_ro: assert property (p_rf_ro)
    else $error("RF write to read-only block accepted");

  property p_ser_ro;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && !cmd_rf && user && map_ff[1][cmd_blk]
        |=> !mem_we ##0 rsp_valid;
  endproperty
  a_ser_ro: assert property (p_ser_ro)
    else $error("serial write to read-only block accepted");

  property p_ser_noqual;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && !cmd_rf && !map_ff[1][cmd_blk]
        |=> mem_we && mem_addr == $past(cmd_addr);
  endproperty
  a_ser_noqual: assert property (p_ser_noqual)
    else $error("serial write blocked by qualifier");

  property p_sys_open;
    @(posedge mclk) disable iff (rst)
      go && cmd_write && cmd_blk >= SYS_BLK_LO |=> mem_we;
  endproperty
  a_sys_open: assert property (p_sys_open)
    else $error("system block write refused");

  property p_reset_maps;
    @(posedge mclk) rst |=> map_ff == '0 && !mem_we && !rsp_valid;
  endproperty
  a_reset_maps: assert property (p_reset_maps)
    else $error("maps not cleared by reset");

  property p_rf_byte3;
    @(posedge mclk) disable iff (rst)
      wr_go && cmd_addr == RF_MAP_OFS + 9'h003
        |=> map_ff[0][26:24] == $past(cmd_wdata[2:0]);
  endproperty
  a_rf_byte3: assert property (p_rf_byte3)
    else $error("RF map top byte not stored");

  property p_ser_byte0;
    @(posedge mclk) disable iff (rst)
      wr_go && cmd_addr == SER_MAP_OFS
        |=> map_ff[1][7:0] == $past(cmd_wdata);
  endproperty
  a_ser_byte0: assert property (p_ser_byte0)
    else $error("serial map byte not stored");

  property p_qual_byte1;
    @(posedge mclk) disable iff (rst)
      wr_go && cmd_addr == QUAL_MAP_OFS + 9'h001
        |=> map_ff[2][15:8] == $past(cmd_wdata);
  endproperty
  a_qual_byte1: assert property (p_qual_byte1)
    else $error("qualifier map byte not stored");

  c_refused: cover property (@(posedge mclk) disable iff (rst)
    go && cmd_write ##1 rsp_valid && !rsp_ok);
  c_enc_ok: cover property (@(posedge mclk) disable iff (rst)
    go && cmd_rf && cmd_encrypted && map_ff[2] != '0 ##1 mem_we);
  c_map_set: cover property (@(posedge mclk) disable iff (rst)
    wr_go && cmd_addr == SER_MAP_OFS ##1 map_ff[1] != '0);
endmodule
`default_nettype wire

// [verif/nbac_cmd_src.sv]
// Command source standing in for the RF reader and the serial host.
// Assumes the block takes a command at the edge after it is driven.
`timescale 1ns/1ps
`default_nettype none
module nbac_cmd_src (
  input  wire logic                   mclk,
  output logic                        cmd_valid,
  output logic                        cmd_write,
  output logic                        cmd_rf,
  output logic                        cmd_encrypted,
  output logic [nbac_pkg::ADDR_W-1:0] cmd_addr,
  output logic [7:0]                  cmd_wdata
);
  import nbac_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_rf = 1'b0;
    cmd_encrypted = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
  end
  // Released address and data lines are inverted so a stale address never looks valid.
  task automatic issue(input logic w, input logic rf, input logic enc,
                       input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] dv;
    dv = d;
    if (w && a[8:4] == 5'h1f && a[1:0] == 2'h3 && a[3:2] != 2'h3)
      dv = d & 8'h07;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_rf <= rf;
    cmd_encrypted <= enc;
    cmd_addr <= a;
    cmd_wdata <= dv;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_wdata <= ~dv;
    #1;
  endtask
endmodule
`default_nettype wire

// [verif/test_nbac_access_ctrl.sv]
// Self-checking bench for the block access controller.
// Assumes the command source model drives every command input.
`timescale 1ns/1ps
`default_nettype none
module test_nbac_access_ctrl;
  import nbac_pkg::*;
  logic              mclk;
  logic              rst;
  logic              ce;
  logic              cmd_valid;
  logic              cmd_write;
  logic              cmd_rf;
  logic              cmd_encrypted;
  logic [ADDR_W-1:0] cmd_addr;
  logic [7:0]        cmd_wdata;
  logic              rsp_valid;
  logic              rsp_ok;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_wdata;
  int                failures;
  int                n_compared;
  int                cycles;

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  nbac_cmd_src src (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_rf(cmd_rf), .cmd_encrypted(cmd_encrypted),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
  nbac_access_ctrl dut (.mclk(mclk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_rf(cmd_rf),
    .cmd_encrypted(cmd_encrypted), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang counts as a mismatch and still reaches the closing report.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic w, input logic rf, input logic enc,
                     input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic ok);
    src.issue(w, rf, enc, a, d);
    check(16'({rsp_valid, rsp_ok, mem_we}), 16'({1'b1, ok, w & ok}));
    check(16'(mem_addr), 16'(a));
    if (w)
      check(16'(mem_wdata), 16'(d));
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
  endtask

  task automatic t_defaults();
    for (int b = 0; b < NUM_BLOCKS; b++) begin
      cmd(1'b1, b[0], 1'b0, 9'(b * 16 + 14), 8'(b), 1'b1);
      cmd(1'b0, ~b[0], 1'b1, 9'(b * 16 + 14), 8'h00, 1'b1);
    end
    $display("test defaults done");
  endtask

  task automatic t_serial();
    cmd(1'b1, 1'b0, 1'b0, 9'h1f4, 8'h01, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h1f7, 8'h04, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h000, 8'h5a, 1'b0);
    cmd(1'b1, 1'b0, 1'b1, 9'h00f, 8'h5a, 1'b0);
    cmd(1'b0, 1'b0, 1'b0, 9'h00f, 8'h00, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h010, 8'ha5, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h1a0, 8'h3c, 1'b0);
    cmd(1'b1, 1'b1, 1'b0, 9'h000, 8'h11, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h1f8, 8'h04, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h020, 8'h22, 1'b1);
    $display("test serial done");
  endtask

  task automatic t_rf_table();
    logic rfb;
    logic q;
    logic ok;
    cmd(1'b1, 1'b0, 1'b0, 9'h1f1, 8'h0c, 1'b1);
    cmd(1'b1, 1'b1, 1'b0, 9'h1f9, 8'h0a, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rfb = i[1];
      q = i[0];
      ok = i[2] ? (i[3] ? (!rfb | q) : 1'b1)
                : (i[3] ? (!rfb & !q) : (rfb | !q));
      cmd(i[3], 1'b1, i[2], 9'((8 + i % 4) * 16 + 5), 8'(i), ok);
    end
    cmd(1'b1, 1'b1, 1'b0, 9'h1f3, 8'h01, 1'b1);
    cmd(1'b1, 1'b1, 1'b0, 9'h180, 8'h77, 1'b0);
    cmd(1'b1, 1'b1, 1'b0, 9'h190, 8'h77, 1'b1);
    $display("test rf table done");
  endtask

  // A frozen block must neither answer nor load the serial map.
  task automatic t_freeze();
    @(posedge mclk);
    ce <= 1'b0;
    src.issue(1'b1, 1'b0, 1'b0, 9'h1f4, 8'h02);
    check(16'({rsp_valid, rsp_ok, mem_we}), 16'h0000);
    check(16'(mem_addr), 16'h0190);
    @(posedge mclk);
    ce <= 1'b1;
    cmd(1'b1, 1'b0, 1'b0, 9'h010, 8'h33, 1'b1);
    cmd(1'b1, 1'b0, 1'b0, 9'h000, 8'h33, 1'b0);
    $display("test clock enable done");
  endtask

  task automatic t_rereset();
    do_reset();
    cmd(1'b1, 1'b0, 1'b0, 9'h000, 8'h99, 1'b1);
    cmd(1'b1, 1'b1, 1'b0, 9'h0a5, 8'h99, 1'b1);
    $display("test reset again done");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    do_reset();
    t_defaults();
    t_serial();
    t_rf_table();
    t_freeze();
    t_rereset();
    complete_run();
  end
endmodule
`default_nettype wire
